// File: boot_programmer.sv
// Overview of operation
// - First all-ones byte starts the boot phase, earlier bytes are dropped; the receiver runs fixed at 1200 baud.
// - Every boot byte received is echoed back on the transmitter.
// - After the last boot byte, control passes to boot code unasked.
// - Boot code drives port C bit 0 low, sets pointers, enters programming.
// - Receiver holds a full byte while the next one arrives.
// - Each programmed location is read back and sent to the host.
// - Device sends a ready character before taking programming data.
// - Programming starts at d000 and advances one location per byte.
module boot_programmer #(
  parameter int unsigned BIT_CYC  = boot_pkg::BIT_CYCLES,
  parameter int unsigned BOOT_LEN = boot_pkg::BOOT_LEN,
  parameter int unsigned FDEPTH   = boot_pkg::FIFO_DEPTH
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             portc0_o,
  output logic             mem_we_o,
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        mem_done_i,
  output logic             prog_mode_o
);
  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  stream_if #(.W(8)) rx_s ();
  stream_if #(.W(8)) buf_s ();

  logic [31:0] rx_cnt_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_busy_r;
  logic        rx_vld_r;
  logic [7:0]  rx_dat_r;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_cnt_r  <= '0;
      rx_bit_r  <= '0;
      rx_sh_r   <= '0;
      rx_busy_r <= 1'b0;
      rx_vld_r  <= 1'b0;
      rx_dat_r  <= '0;
    end else begin
      if (rx_vld_r && rx_s.ready) begin
        rx_vld_r <= 1'b0;
      end
      if (!rx_busy_r) begin
        if (!rxd_i) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= 32'(BIT_CYC / 2);
          rx_bit_r  <= '0;
        end
      end else if (rx_cnt_r != 0) begin
        rx_cnt_r <= rx_cnt_r - 1;
      end else begin
        rx_cnt_r <= 32'(BIT_CYC - 1);
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rxd_i) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
          rx_sh_r <= {rxd_i, rx_sh_r[7:1]};
        end else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          if (rxd_i) begin
            rx_vld_r <= 1'b1;
            rx_dat_r <= rx_sh_r;
          end
        end
      end
    end
  end

  assign rx_s.valid = rx_vld_r;
  assign rx_s.data  = rx_dat_r;

  byte_fifo #(.W(8), .D(FDEPTH)) u_fifo (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .in_s   (rx_s),
    .out_s  (buf_s)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [31:0] tx_cnt_r;
  logic [3:0]  tx_bit_r;
  logic [9:0]  tx_sh_r;
  logic        tx_busy_r;
  logic        tx_go;
  logic [7:0]  tx_byte;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cnt_r  <= '0;
      tx_bit_r  <= '0;
      tx_sh_r   <= '1;
      tx_busy_r <= 1'b0;
    end else if (tx_go) begin
      tx_busy_r <= 1'b1;
      tx_sh_r   <= {1'b1, tx_byte, 1'b0};
      tx_cnt_r  <= 32'(BIT_CYC - 1);
      tx_bit_r  <= '0;
    end else if (tx_busy_r) begin
      if (tx_cnt_r != 0) begin
        tx_cnt_r <= tx_cnt_r - 1;
      end else begin
        tx_cnt_r <= 32'(BIT_CYC - 1);
        tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_bit_r == 4'h9) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end

  assign txd_o = tx_sh_r[0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  boot_pkg::phase_e ph_r;
  logic [15:0]      boot_cnt_r;
  logic [15:0]      addr_r;
  logic [7:0]       wdat_r;
  logic             we_r;
  logic             pc0_r;

  always_comb begin
    tx_go   = 1'b0;
    tx_byte = buf_s.data;
    buf_s.ready = 1'b0;
    case (ph_r)
      boot_pkg::ST_SYNC: begin
        buf_s.ready = buf_s.valid;
      end
      boot_pkg::ST_BOOT: begin
        buf_s.ready = buf_s.valid & ~tx_busy_r;
        tx_go       = buf_s.ready;
      end
      boot_pkg::ST_READY: begin
        tx_go   = ~tx_busy_r;
        tx_byte = boot_pkg::READY_BYTE;
      end
      boot_pkg::ST_DATA: begin
        buf_s.ready = buf_s.valid;
      end
      boot_pkg::ST_VERIFY: begin
        tx_go   = ~tx_busy_r;
        tx_byte = mem_rdata_i;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_r       <= boot_pkg::ST_SYNC;
      boot_cnt_r <= '0;
      addr_r     <= boot_pkg::PROG_START;
      wdat_r     <= '0;
      we_r       <= 1'b0;
      pc0_r      <= boot_pkg::PORTC0_RST;
    end else begin
      we_r <= 1'b0;
      case (ph_r)
        boot_pkg::ST_SYNC: begin
          if (buf_s.valid && buf_s.data == boot_pkg::SYNC_BYTE) begin
            ph_r <= boot_pkg::ST_BOOT;
          end
        end
        boot_pkg::ST_BOOT: begin
          if (buf_s.ready) begin
            boot_cnt_r <= boot_cnt_r + 16'h0001;
            if (boot_cnt_r == 16'(BOOT_LEN - 1)) begin
              ph_r <= boot_pkg::ST_RUN;
            end
          end
        end
        boot_pkg::ST_RUN: begin
          pc0_r  <= 1'b0;
          addr_r <= boot_pkg::PROG_START;
          ph_r   <= boot_pkg::ST_READY;
        end
        boot_pkg::ST_READY: begin
          if (tx_go) begin
            ph_r <= boot_pkg::ST_DATA;
          end
        end
        boot_pkg::ST_DATA: begin
          if (buf_s.valid) begin
            wdat_r <= buf_s.data;
            we_r   <= 1'b1;
            ph_r   <= boot_pkg::ST_PROG;
          end
        end
        boot_pkg::ST_PROG: begin
          if (mem_done_i) begin
            ph_r <= boot_pkg::ST_VERIFY;
          end
        end
        boot_pkg::ST_VERIFY: begin
          if (tx_go) begin
            addr_r <= addr_r + 16'h0001;
            ph_r   <= boot_pkg::ST_DATA;
          end
        end
        default: begin
          ph_r <= boot_pkg::ST_SYNC;
        end
      endcase
    end
  end

  assign mem_we_o    = we_r;
  assign mem_addr_o  = addr_r;
  assign mem_wdata_o = wdat_r;
  assign portc0_o    = pc0_r;
  assign prog_mode_o = (ph_r == boot_pkg::ST_DATA) | (ph_r == boot_pkg::ST_PROG) |
                       (ph_r == boot_pkg::ST_VERIFY);
endmodule : boot_programmer

// File: boot_pkg.sv
package boot_pkg;
  // ----------------------------------------------------------------
  // Serial timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned BAUD        = 1200;
  localparam int unsigned BIT_CYCLES  = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS   = 8;
  // ----------------------------------------------------------------
  // Memory layout and protocol values
  // ----------------------------------------------------------------
  localparam logic [15:0] PROG_START  = 16'hd000;
  localparam logic [7:0]  SYNC_BYTE   = 8'hff;
  localparam logic [7:0]  READY_BYTE  = 8'hff;
  localparam logic [7:0]  BLANK_BYTE  = 8'hff;
  localparam int unsigned BOOT_LEN    = 8;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam logic        PORTC0_RST  = 1'b1;

  typedef enum logic [2:0] {
    ST_SYNC, ST_BOOT, ST_RUN, ST_READY, ST_DATA, ST_PROG, ST_VERIFY
  } phase_e;
endpackage : boot_pkg

// File: stream_if.sv
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input  ready);
  modport sink (input  valid, input  data, output ready);
endinterface : stream_if

// File: byte_fifo.sv
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  stream_if.sink    in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic [W-1:0]  dout_r;
  logic          dval_r;
  logic          push;
  logic          pop;
  logic          load;

  assign in_s.ready  = (cnt_r != D[AW:0]);
  assign push        = in_s.valid & in_s.ready;
  assign load        = (cnt_r != '0) & (~dval_r | out_s.ready);
  assign pop         = load;
  assign out_s.valid = dval_r;
  assign out_s.data  = dout_r;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_s.data;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_r   <= '0;
      rd_r   <= '0;
      cnt_r  <= '0;
      dout_r <= '0;
      dval_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r   <= rd_r + 1'b1;
        dout_r <= mem_r[rd_r];
        dval_r <= 1'b1;
      end else if (out_s.ready) begin
        dval_r <= 1'b0;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : byte_fifo

// File: bp_chk_sva.sv
module bp_chk #(parameter int unsigned BIT_CYC = 16) (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        txd_o,
  input wire logic        portc0_o,
  input wire logic        mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        mem_done_i,
  input wire logic        prog_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run_r;
  logic        pend_r;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Idle counts as a long stable run
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) run_r <= 32'hffffffff;
    else if ($changed(txd_o)) run_r <= 32'h0;
    else if (~&run_r) run_r <= run_r + 32'h1;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) pend_r <= 1'b0;
    else if (mem_we_o) pend_r <= 1'b1;
    else if (mem_done_i) pend_r <= 1'b0;
  end
  a_we_pulse: assert property (mem_we_o |=> !mem_we_o)
    else $error("strobe too long");
  a_one_pend: assert property (mem_we_o |-> !pend_r)
    else $error("write before done");
  a_wr_hold: assert property (pend_r |-> $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("write moved");
  a_addr_step: assert property ($changed(mem_addr_o) |-> mem_addr_o == $past(mem_addr_o) + 16'h1)
    else $error("bad step");
  a_addr_base: assert property (!prog_mode_o |-> mem_addr_o == boot_pkg::PROG_START)
    else $error("bad base");
  a_we_mode: assert property (mem_we_o |-> prog_mode_o)
    else $error("write too early");
  a_port_mode: assert property (prog_mode_o |-> !portc0_o)
    else $error("port high");
  a_port_stay: assert property (!portc0_o |=> !portc0_o)
    else $error("port rose");
  a_bit_len: assert property ($changed(txd_o) |-> run_r >= BIT_CYC - 1)
    else $error("short bit");
  c_prog: cover property (mem_we_o);
  c_run: cover property ($fell(portc0_o));
  c_next: cover property (mem_we_o && mem_addr_o != boot_pkg::PROG_START);
endmodule : bp_chk

bind boot_programmer bp_chk #(.BIT_CYC(BIT_CYC)) u_chk (.mclk_i, .rstn_i, .txd_o, .portc0_o,
  .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_done_i, .prog_mode_o);

// File: host_model.sv
module host_model #(parameter int BC = 16) (
  input wire logic  mclk_i,
  input wire logic  txd_i,
  output logic       rxd_o,
  output logic [8:0] got_o,
  output logic       got_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BC) @(posedge mclk_i);
    end
  endtask : send
  // mid-bit sampling, stop kept in bit 8
  initial begin
    rxd_o = 1'b1;
    got_o = 9'h000;
    got_stb_o = 1'b0;
    forever begin
      @(negedge txd_i);
      repeat (BC / 2) @(negedge mclk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BC) @(negedge mclk_i);
        got_o[i] = txd_i;
      end
      got_stb_o = 1'b1;
      @(negedge mclk_i);
      got_stb_o = 1'b0;
    end
  end
endmodule : host_model

// File: tb_serial_boot_eprom_programmer.sv
module tb_serial_boot_eprom_programmer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 16;
  localparam int BL = 4;
  localparam int ND = 6;
  logic        mclk_i, rstn_i, rxd_i, txd_o, portc0_o, mem_we_o, mem_done_i, prog_mode_o, got_stb;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_wdata_o, mem_rdata_i, wv, b;
  logic [8:0]  got;
  logic [8:0]  tx_q[$];
  logic [23:0] wr_q[$];
  int          n_fail, n_tests, n_got;
  boot_programmer #(.BIT_CYC(BC), .BOOT_LEN(BL)) uut (.mclk_i, .rstn_i, .rxd_i, .txd_o, .portc0_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_done_i, .prog_mode_o);
  host_model #(.BC(BC)) host (.mclk_i, .txd_i(txd_o), .rxd_o(rxd_i), .got_o(got), .got_stb_o(got_stb));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic bad(input logic [23:0] e, input logic [23:0] a);
    n_fail++;
    $display("unexpected at %0t: exp %h got %h", $time, e, a);
  endtask : bad
  task automatic chk_tx(input logic [8:0] e, input logic [8:0] a);
    n_tests++;
    if (e !== a) bad({15'h0, e}, {15'h0, a});
  endtask : chk_tx
  task automatic chk_wr(input logic [23:0] e, input logic [23:0] a);
    n_tests++;
    if (e !== a) bad(e, a);
  endtask : chk_wr
  task automatic chk_pin(input logic [1:0] e, input logic [1:0] a);
    n_tests++;
    if (e !== a) bad({22'h0, e}, {22'h0, a});
  endtask : chk_pin
  task automatic wt(input int n);
    for (int k = 0; k < 20000 && n_got < n; k++) @(posedge mclk_i);
  endtask : wt
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Memory answers after a random wait, garbage while busy
  initial begin
    mem_done_i = 1'b0;
    mem_rdata_i = 8'h00;
    forever begin
      @(posedge mclk_i);
      if (mem_we_o === 1'b1) begin
        wv = mem_wdata_o;
        mem_rdata_i <= ~wv;
        repeat ($urandom_range(200, 1)) @(posedge mclk_i);
        mem_done_i <= 1'b1;
        mem_rdata_i <= wv;
        @(posedge mclk_i);
        mem_done_i <= 1'b0;
      end
    end
  end
  // host side check of every result
  always @(posedge mclk_i) begin
    if (got_stb === 1'b1) begin
      n_got++;
      chk_tx(tx_q.size() ? tx_q.pop_front() : 9'h000, got);
    end
    if (mem_we_o === 1'b1) chk_wr(wr_q.size() ? wr_q.pop_front() : 24'h0, {mem_addr_o, mem_wdata_o});
  end
  initial begin
    rstn_i = 1'b0;
    void'($urandom(40795));
    repeat (8) @(posedge mclk_i);
    chk_pin(2'b10, {portc0_o, prog_mode_o});
    rstn_i <= 1'b1;
    host.send(8'h55);
    host.send(boot_pkg::SYNC_BYTE);
    for (int i = 0; i < BL; i++) begin
      b = 8'($urandom);
      tx_q.push_back({1'b1, b});
      host.send(b);
    end
    tx_q.push_back({1'b1, boot_pkg::READY_BYTE});
    wt(BL + 1);
    chk_pin(2'b01, {portc0_o, prog_mode_o});
    for (int i = 0; i < ND; i++) begin
      b = 8'($urandom);
      tx_q.push_back({1'b1, b});
      wr_q.push_back({boot_pkg::PROG_START + 16'(i), b});
      host.send(b);
      if (i > 0) wt(BL + 1 + i);
    end
    wt(BL + 1 + ND);
    // Missing results would otherwise slip through a timed-out wait
    chk_wr(24'h0, 24'(tx_q.size() + wr_q.size()));
    close_out();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_fail++;
    close_out();
  end
endmodule : tb_serial_boot_eprom_programmer
